// ---- pkg/vm_exit_qual_consts.svh ----
/*
  Offsets, field positions and reset values for the exit qualification
  encoder. Assumes inclusion by bare name from the package and design.
*/
`ifndef VM_EXIT_QUAL_CONSTS_SVH
`define VM_EXIT_QUAL_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_QUAL_LO 5'h00
`define OFS_QUAL_HI 5'h04
`define OFS_STATUS 5'h08
`define OFS_CTRL 5'h0C
`define OFS_COUNT 5'h10

// ==========================================================
// Status and control fields
`define ST_VALID_BIT 0
`define ST_CAUSE_LSB 1
`define ST_VECVAL_BIT 4
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 1'h1

// ==========================================================
// Qualification field positions
`define DR_INDEX_LSB 0
`define DR_DIR_BIT 4
`define DR_GPR_LSB 8
`define IO_SIZE_LSB 0
`define IO_DIR_BIT 3
`define IO_STRING_BIT 4
`define IO_REPEAT_BIT 5
`define IO_IMM_BIT 6
`define IO_PORT_LSB 16
`define AP_OFFSET_LSB 0
`define AP_TYPE_LSB 12
`define NV_READ_BIT 0
`define NV_WRITE_BIT 1
`define NV_FETCH_BIT 2
`define NV_READABLE_BIT 3

// ==========================================================
// Encodings
`define IO_SIZE_1B 3'h0
`define IO_SIZE_2B 3'h1
`define IO_SIZE_4B 3'h3
`define AP_LIN_READ 4'h0
`define AP_LIN_WRITE 4'h1
`define AP_LIN_FETCH 4'h2
`define AP_LIN_EVENT 4'h3
`define AP_GP_EVENT 4'hA
`define AP_GP_FETCH 4'hF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define NPT_LEVELS 4

`endif

// ---- pkg/vm_exit_qual_pkg.sv ----
/*
  Types for the exit qualification encoder: exit causes, access
  classes and the registered state of the block.
  Assumes the constants header is on the include path.
*/
`include "vm_exit_qual_consts.svh"

package vm_exit_qual_pkg;

  typedef enum logic [2:0] {
    cause_debug_register_move,
    cause_port_io,
    cause_monitor_wait_instruction,
    cause_apic_page,
    cause_nested_page_table
  } exit_cause_t;

  // Width of a port access as seen by the decoder
  typedef enum logic [1:0] {
    io_width_byte,
    io_width_word,
    io_width_dword
  } io_width_t;

  typedef enum logic [2:0] {
    apic_linear_data,
    apic_linear_fetch,
    apic_linear_event,
    apic_gp_event,
    apic_gp_fetch_exec,
    apic_physical
  } apic_kind_t;

  // Instruction classes; all but insn_other have a fixed access type
  typedef enum logic [2:0] {
    insn_other,
    insn_cache_line_flush_instruction,
    insn_monitor_arm,
    insn_frame_enter,
    insn_masked_store_narrow,
    insn_masked_store_wide
  } insn_class_t;

  typedef struct packed {
    logic [63:0] qual;
    logic vec_valid;
    logic qual_valid;
    logic [2:0] cause;
    logic cap_en;
    logic [31:0] exit_count;
    logic aw_have;
    logic [4:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

endpackage : vm_exit_qual_pkg

// ---- hw/vm_exit_qualification_encoder.sv ----
/*
  Exit qualification encoder: builds the 64-bit qualification word for
  debug-register moves, port I/O, monitor-wait, interrupt-controller
  page and nested-page-table violation exits, with an AXI4-Lite slave.
  Assumes the pipeline holds the decode inputs valid in the cycle that
  exit_commit is high, and that the package is compiled first.
*/
`timescale 1ns/1ns
`include "vm_exit_qual_consts.svh"

module vm_exit_qualification_encoder
  import vm_exit_qual_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic exit_commit,
  input wire exit_cause_t exit_cause,
  input wire logic [2:0] dr_index,
  input wire logic dr_read,
  input wire logic [3:0] gpr_code,
  input wire io_width_t io_width,
  input wire logic io_in,
  input wire logic io_string,
  input wire logic io_repeat_prefix,
  input wire logic io_immediate,
  input wire logic [15:0] io_port,
  input wire logic monitor_armed,
  input wire apic_kind_t apic_kind,
  input wire insn_class_t apic_insn,
  input wire logic apic_fault_write,
  input wire logic [11:0] apic_offset,
  input wire logic npt_read,
  input wire logic npt_write,
  input wire logic npt_fetch,
  input wire logic [3:0] npt_used,
  input wire logic [3:0] npt_present,
  input wire logic [3:0] npt_readable,
  output logic [63:0] qual,
  output logic qual_valid,
  output logic vector_valid,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  state_t st_r;
  state_t st_nxt;
  logic [63:0] enc;
  logic enc_vec;
  logic [3:0] ap_type;
  logic walk_readable;
  logic walk_missing;
  logic [3:0] lvl_ok;
  logic [31:0] rd_word;
  logic rd_ok;

  // ==========================================================
  // Translation walk summary
  genvar g;
  generate
    for (g = 0; g < `NPT_LEVELS; g = g + 1)
    begin : g_walk
      // Unused levels must not veto the AND
      assign lvl_ok[g] = !npt_used[g] || npt_readable[g];
    end
  endgenerate

  assign walk_readable = &lvl_ok;
  assign walk_missing = |(npt_used & ~npt_present);

  // ==========================================================
  // Register read decode
  function automatic logic [32:0] reg_read(input logic [4:0] addr,
                                           input state_t s);
    logic [32:0] r;
    r = {1'h0, 32'h0};
    if (addr == `OFS_QUAL_LO)
      r = {1'h1, s.qual[31:0]};
    else if (addr == `OFS_QUAL_HI)
      r = {1'h1, s.qual[63:32]};
    else if (addr == `OFS_STATUS)
    begin
      r[32] = 1'h1;
      r[`ST_VALID_BIT] = s.qual_valid;
      r[`ST_CAUSE_LSB +: 3] = s.cause;
      r[`ST_VECVAL_BIT] = s.vec_valid;
    end
    else if (addr == `OFS_CTRL)
    begin
      r[32] = 1'h1;
      r[`CTRL_ENABLE_BIT] = s.cap_en;
    end
    else if (addr == `OFS_COUNT)
      r = {1'h1, s.exit_count};
    return r;
  endfunction : reg_read

  // ==========================================================
  // Interrupt-controller page access type
  always_comb
  begin
    ap_type = `AP_LIN_READ;
    case (apic_kind)
      apic_linear_data:
      begin
        // Same sense as the page-fault W/R bit
        ap_type = apic_fault_write ? `AP_LIN_WRITE : `AP_LIN_READ;
        case (apic_insn)
          insn_cache_line_flush_instruction,
          insn_monitor_arm:
            ap_type = `AP_LIN_READ;
          insn_frame_enter,
          insn_masked_store_narrow,
          insn_masked_store_wide:
            ap_type = `AP_LIN_WRITE;
          default:
            ap_type = ap_type;
        endcase
      end
      apic_linear_fetch: ap_type = `AP_LIN_FETCH;
      apic_linear_event: ap_type = `AP_LIN_EVENT;
      apic_gp_event: ap_type = `AP_GP_EVENT;
      apic_gp_fetch_exec: ap_type = `AP_GP_FETCH;
      default: ap_type = `AP_LIN_READ;
    endcase
  end

  // ==========================================================
  // Qualification word assembly
  always_comb
  begin
    enc = 64'h0;
    enc_vec = 1'h0;
    case (exit_cause)
      cause_debug_register_move:
      begin
        enc[`DR_INDEX_LSB +: 3] = dr_index;
        enc[`DR_DIR_BIT] = dr_read;
        enc[`DR_GPR_LSB +: 4] = gpr_code;
      end
      cause_port_io:
      begin
        case (io_width)
          io_width_word: enc[`IO_SIZE_LSB +: 3] = `IO_SIZE_2B;
          io_width_dword: enc[`IO_SIZE_LSB +: 3] = `IO_SIZE_4B;
          default: enc[`IO_SIZE_LSB +: 3] = `IO_SIZE_1B;
        endcase
        enc[`IO_DIR_BIT] = io_in;
        enc[`IO_STRING_BIT] = io_string;
        enc[`IO_REPEAT_BIT] = io_repeat_prefix;
        enc[`IO_IMM_BIT] = io_immediate;
        enc[`IO_PORT_LSB +: 16] = io_port;
      end
      cause_monitor_wait_instruction:
        enc[0] = monitor_armed;
      cause_apic_page:
      begin
        // Physical accesses carry no layout; zero is the safe choice
        if (apic_kind != apic_physical)
        begin
          if (apic_kind == apic_linear_data ||
              apic_kind == apic_linear_fetch ||
              apic_kind == apic_linear_event)
            enc[`AP_OFFSET_LSB +: 12] = apic_offset;
          enc[`AP_TYPE_LSB +: 4] = ap_type;
          enc_vec = (ap_type == `AP_LIN_EVENT) ||
                    (ap_type == `AP_GP_EVENT);
        end
      end
      cause_nested_page_table:
      begin
        enc[`NV_READ_BIT] = npt_read;
        enc[`NV_WRITE_BIT] = npt_write;
        enc[`NV_FETCH_BIT] = npt_fetch;
        enc[`NV_READABLE_BIT] = walk_readable && !walk_missing;
      end
      default:
        enc = 64'h0;
    endcase
  end

  // ==========================================================
  // Next state: capture plus AXI4-Lite slave
  always_comb
  begin
    st_nxt = st_r;
    rd_word = 32'h0;
    rd_ok = 1'h0;
    if (exit_commit && st_r.cap_en)
    begin
      st_nxt.qual = enc;
      st_nxt.vec_valid = enc_vec;
      st_nxt.qual_valid = 1'h1;
      st_nxt.cause = exit_cause;
      st_nxt.exit_count = st_r.exit_count + 32'h1;
    end
    // Write side: address and data taken in either order
    if (s_axi_awvalid && st_r.awready)
    begin
      st_nxt.aw_have = 1'h1;
      st_nxt.aw_addr = s_axi_awaddr[4:0];
    end
    if (s_axi_wvalid && st_r.wready)
    begin
      st_nxt.w_have = 1'h1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'h0;
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid)
    begin
      st_nxt.aw_have = 1'h0;
      st_nxt.w_have = 1'h0;
      st_nxt.bvalid = 1'h1;
      st_nxt.bresp = `RESP_SLVERR;
      if (st_r.aw_addr == `OFS_CTRL)
      begin
        st_nxt.bresp = `RESP_OKAY;
        if (st_r.w_strb[0])
          st_nxt.cap_en = st_r.w_data[`CTRL_ENABLE_BIT];
      end
      else if (st_r.aw_addr == `OFS_QUAL_LO ||
               st_r.aw_addr == `OFS_QUAL_HI ||
               st_r.aw_addr == `OFS_STATUS ||
               st_r.aw_addr == `OFS_COUNT)
        // Read-only words accept and ignore writes
        st_nxt.bresp = `RESP_OKAY;
    end
    // Read side
    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'h0;
    if (s_axi_arvalid && st_r.arready)
    begin
      {rd_ok, rd_word} = reg_read(s_axi_araddr[4:0], st_r);
      st_nxt.rvalid = 1'h1;
      st_nxt.rdata = rd_word;
      st_nxt.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      st_r.cap_en <= `CTRL_RESET;
    end
    else
      st_r <= st_nxt;
  end

  // ==========================================================
  // Outputs
  assign qual = st_r.qual;
  assign qual_valid = st_r.qual_valid;
  assign vector_valid = st_r.vec_valid;
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence seq_take(exit_cause_t c);
    exit_commit && st_r.cap_en && exit_cause == c;
  endsequence

  chk_dr_index: assert property (
    seq_take(cause_debug_register_move) |=> qual[2:0] == $past(dr_index))
    else $error("debug index field wrong");

  chk_dr_dir: assert property (
    seq_take(cause_debug_register_move) |=> qual[4] == $past(dr_read))
    else $error("debug direction bit wrong");

  chk_dr_gpr: assert property (
    seq_take(cause_debug_register_move) |=> qual[11:8] == $past(gpr_code))
    else $error("debug gpr field wrong");

  chk_dr_zero: assert property (
    seq_take(cause_debug_register_move) |=>
      qual[63:12] == 52'h0 && qual[7:5] == 3'h0 && !qual[3])
    else $error("debug reserved bits set");

  chk_io_size: assert property (
    seq_take(cause_port_io) |=> qual[2:0] != 3'h2 && !qual[2])
    else $error("io size code illegal");

  chk_io_flags: assert property (
    seq_take(cause_port_io) |=> qual[6:3] == $past({io_immediate,
      io_repeat_prefix, io_string, io_in}))
    else $error("io flag bits wrong");

  chk_io_port: assert property (
    seq_take(cause_port_io) |=> qual[31:16] == $past(io_port) &&
      qual[63:32] == 32'h0 && qual[15:7] == 9'h0)
    else $error("io port field wrong");

  chk_monitor_wait: assert property (
    seq_take(cause_monitor_wait_instruction) |=>
      qual == {63'h0, $past(monitor_armed)})
    else $error("monitor wait value wrong");

  chk_apic_vector: assert property (
    qual_valid |-> vector_valid == (qual[15:12] == `AP_LIN_EVENT ||
      qual[15:12] == `AP_GP_EVENT) || st_r.cause != cause_apic_page)
    else $error("vector valid mismatch");

  chk_apic_upper: assert property (
    seq_take(cause_apic_page) |=> qual[63:16] == 48'h0)
    else $error("page exit upper bits set");

  chk_npt_missing: assert property (
    seq_take(cause_nested_page_table) ##0 walk_missing |=> !qual[3])
    else $error("readable set with missing entry");

  chk_hold_idle: assert property (
    !exit_commit |=> $stable(qual))
    else $error("qualification changed without exit");

endmodule : vm_exit_qualification_encoder

// ---- verification/tb.sv ----
/*
  Self-checking bench for the exit qualification encoder: a table of
  exits for every format, then bus, capture enable and reset cases.
  Assumes the package and the constants header are compiled first.
*/
`timescale 1ns/1ns
`include "vm_exit_qual_consts.svh"

module tb
  import vm_exit_qual_pkg::*;
;
  // ==========================================================
  // Stimulus types
  typedef struct packed {
    exit_cause_t c;
    logic [2:0] dri;
    logic drr;
    logic [3:0] gpr;
    io_width_t w;
    logic [3:0] io;
    logic [15:0] port;
    logic mon;
    apic_kind_t ak;
    insn_class_t ai;
    logic fw;
    logic [11:0] off;
    logic [2:0] acc;
    logic [3:0] used;
    logic [3:0] pres;
    logic [3:0] rd;
  } stim_t;

  // Value 2 in v means vector_valid is not compared
  typedef struct packed {
    stim_t s;
    logic [63:0] q;
    logic [1:0] v;
  } row_t;

  // Every field set, so stray bits leak into the word if not masked
  localparam stim_t noise = '{cause_apic_page, 3'h7, 1'b1, 4'hF,
    io_width_dword, 4'hF, 16'hFFFF, 1'b1, apic_linear_event,
    insn_frame_enter, 1'b1, 12'hFFF, 3'h7, 4'hF, 4'hF, 4'hF};

  logic aclk;
  logic aresetn;
  logic exit_commit;
  stim_t cur;
  logic [63:0] qual;
  logic qual_valid;
  logic vector_valid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] rdat;
  row_t rows[$];
  int error_cnt;
  int comparisons;

  vm_exit_qualification_encoder dut (
    .aclk(aclk), .aresetn(aresetn), .exit_commit(exit_commit),
    .exit_cause(cur.c), .dr_index(cur.dri), .dr_read(cur.drr),
    .gpr_code(cur.gpr), .io_width(cur.w), .io_in(cur.io[3]),
    .io_string(cur.io[2]), .io_repeat_prefix(cur.io[1]),
    .io_immediate(cur.io[0]), .io_port(cur.port), .monitor_armed(cur.mon),
    .apic_kind(cur.ak), .apic_insn(cur.ai), .apic_fault_write(cur.fw),
    .apic_offset(cur.off), .npt_read(cur.acc[2]), .npt_write(cur.acc[1]),
    .npt_fetch(cur.acc[0]), .npt_used(cur.used), .npt_present(cur.pres),
    .npt_readable(cur.rd), .qual(qual), .qual_valid(qual_valid),
    .vector_valid(vector_valid), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input string name, input logic [63:0] seen,
    input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // Called just after a rising edge; ends one edge after the answer
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] st, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= {27'h0, a};
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("write answer", n < 40, 1'b1);
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= {27'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("read answer", n < 40, 1'b1);
    @(posedge aclk);
  endtask : axi_rd

  // ==========================================================
  // Row builders, one per format
  task automatic dr(input logic [2:0] i, input logic d, input logic [3:0] g,
    input logic [63:0] q);
    stim_t s;
    s = noise;
    s.c = cause_debug_register_move;
    s.dri = i;
    s.drr = d;
    s.gpr = g;
    rows.push_back('{s, q, 2'h2});
  endtask : dr

  task automatic io(input io_width_t w, input logic [3:0] f,
    input logic [15:0] p, input logic [63:0] q);
    stim_t s;
    s = noise;
    s.c = cause_port_io;
    s.w = w;
    s.io = f;
    s.port = p;
    rows.push_back('{s, q, 2'h2});
  endtask : io

  task automatic mw(input logic m, input logic [63:0] q);
    stim_t s;
    s = noise;
    s.c = cause_monitor_wait_instruction;
    s.mon = m;
    rows.push_back('{s, q, 2'h2});
  endtask : mw

  task automatic ap(input apic_kind_t k, input insn_class_t i,
    input logic f, input logic [11:0] o, input logic [63:0] q,
    input logic [1:0] v);
    stim_t s;
    s = noise;
    s.ak = k;
    s.ai = i;
    s.fw = f;
    s.off = o;
    rows.push_back('{s, q, v});
  endtask : ap

  task automatic np(input logic [2:0] a, input logic [3:0] u,
    input logic [3:0] p, input logic [3:0] r, input logic [63:0] q);
    stim_t s;
    s = noise;
    s.c = cause_nested_page_table;
    s.acc = a;
    s.used = u;
    s.pres = p;
    s.rd = r;
    rows.push_back('{s, q, 2'h2});
  endtask : np

  task automatic fire(input stim_t s);
    cur <= s;
    exit_commit <= 1'b1;
    @(posedge aclk);
    exit_commit <= 1'b0;
    @(posedge aclk);
  endtask : fire

  // ==========================================================
  // Watchdog, far beyond the hundred or so cycles the run needs
  initial
  begin
    repeat (3000) @(posedge aclk);
    $display("[ERR] watchdog expected finish seen timeout");
    error_cnt++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    error_cnt = 0;
    comparisons = 0;
    aresetn = 1'b0;
    exit_commit = 1'b0;
    cur = noise;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 32'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    dr(3'h5, 1'b1, 4'hB, 64'h0B15);
    dr(3'h0, 1'b0, 4'hF, 64'h0F00);
    dr(3'h7, 1'b1, 4'h0, 64'h0017);
    io(io_width_byte, 4'h0, 16'h1234, 64'h1234_0000);
    io(io_width_word, 4'hF, 16'hFFFF, 64'hFFFF_0079);
    io(io_width_dword, 4'h8, 16'h8001, 64'h8001_000B);
    io(io_width_dword, 4'h5, 16'h0001, 64'h0001_0053);
    mw(1'b1, 64'h1);
    mw(1'b0, 64'h0);
    ap(apic_linear_data, insn_other, 1'b0, 12'hABC, 64'h0ABC, 2'h0);
    ap(apic_linear_data, insn_other, 1'b1, 12'h004, 64'h1004, 2'h0);
    ap(apic_linear_fetch, insn_other, 1'b1, 12'h3F0, 64'h23F0, 2'h0);
    ap(apic_linear_event, insn_other, 1'b0, 12'h080, 64'h3080, 2'h1);
    ap(apic_gp_event, insn_other, 1'b0, 12'hFFF, 64'hA000, 2'h1);
    ap(apic_gp_fetch_exec, insn_other, 1'b0, 12'hFFF, 64'hF000, 2'h0);
    ap(apic_physical, insn_other, 1'b1, 12'hFFF, 64'h0, 2'h0);
    ap(apic_linear_data, insn_cache_line_flush_instruction, 1'b1,
      12'h010, 64'h0010, 2'h0);
    ap(apic_linear_data, insn_monitor_arm, 1'b1, 12'h020, 64'h0020, 2'h0);
    ap(apic_linear_data, insn_frame_enter, 1'b0, 12'h030, 64'h1030, 2'h0);
    ap(apic_linear_data, insn_masked_store_narrow, 1'b0,
      12'h040, 64'h1040, 2'h0);
    ap(apic_linear_data, insn_masked_store_wide, 1'b0,
      12'h050, 64'h1050, 2'h0);
    np(3'h4, 4'hF, 4'hF, 4'hF, 64'h9);
    np(3'h2, 4'hF, 4'hF, 4'hD, 64'h2);
    np(3'h1, 4'h3, 4'h3, 4'h3, 64'hC);
    np(3'h4, 4'h3, 4'h1, 4'h3, 64'h1);
    np(3'h6, 4'h1, 4'h1, 4'h1, 64'hB);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk("reset qual", qual, 64'h0);
    chk("reset qual_valid", qual_valid, 1'b0);
    @(posedge aclk);
    axi_rd(`OFS_CTRL, rdat, resp);
    chk("ctrl reset", rdat[0], `CTRL_RESET);
    $display("reset test done");
    // Commits every cycle: each edge launches one row, checks the last
    for (int i = 0; i <= rows.size(); i++)
    begin
      @(posedge aclk);
      if (i < rows.size())
        cur <= rows[i].s;
      exit_commit <= (i < rows.size());
      #1;
      if (i > 0)
      begin
        chk("qual", qual, rows[i-1].q);
        if (rows[i-1].v != 2'h2)
          chk("vector_valid", vector_valid, rows[i-1].v[0]);
      end
    end
    @(posedge aclk);
    chk("qual_valid", qual_valid, 1'b1);
    axi_rd(`OFS_STATUS, rdat, resp);
    chk("status", rdat[3:0], 4'h9);
    axi_rd(`OFS_COUNT, rdat, resp);
    chk("count", rdat, rows.size());
    axi_rd(`OFS_QUAL_LO, rdat, resp);
    chk("qual lo", rdat, rows[$].q[31:0]);
    axi_rd(`OFS_QUAL_HI, rdat, resp);
    chk("qual hi", rdat, 32'h0);
    $display("table test done");
    axi_rd(5'h14, rdat, resp);
    chk("unmapped rresp", resp, `RESP_SLVERR);
    chk("unmapped rdata", rdat, 32'h0);
    axi_wr(5'h1C, 32'hFFFF_FFFF, 4'hF, resp);
    chk("unmapped bresp", resp, `RESP_SLVERR);
    axi_wr(`OFS_QUAL_LO, 32'h1234_5678, 4'hF, resp);
    chk("read-only bresp", resp, `RESP_OKAY);
    chk("read-only qual", qual, rows[$].q);
    axi_wr(`OFS_CTRL, 32'h0, 4'h0, resp);
    axi_rd(`OFS_CTRL, rdat, resp);
    chk("ctrl without strobe", rdat[0], 1'b1);
    $display("refusal test done");
    axi_wr(`OFS_CTRL, 32'h0, 4'hF, resp);
    fire(noise);
    chk("qual held", qual, rows[$].q);
    axi_rd(`OFS_COUNT, rdat, resp);
    chk("count held", rdat, rows.size());
    axi_wr(`OFS_CTRL, 32'h1, 4'hF, resp);
    fire(noise);
    chk("qual enabled", qual, 64'h3FFF);
    chk("vector enabled", vector_valid, 1'b1);
    axi_rd(`OFS_STATUS, rdat, resp);
    chk("status vector", rdat[4:0], 5'h17);
    $display("capture enable test done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("rerun qual", qual, 64'h0);
    chk("rerun qual_valid", qual_valid, 1'b0);
    chk("rerun vector_valid", vector_valid, 1'b0);
    @(posedge aclk);
    axi_rd(`OFS_CTRL, rdat, resp);
    chk("rerun ctrl", rdat[0], `CTRL_RESET);
    axi_rd(`OFS_COUNT, rdat, resp);
    chk("rerun count", rdat, 32'h0);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule : tb
